// ===== test/spi_host_model.sv
// Host model that writes the converter's configuration words.
// Assumes the block samples the serial data on the falling clock edge.
`timescale 1ns/10ps
module spi_host_model (
  input  wire logic mclk_i,
  output logic      sel_n_o,
  output logic      sck_o,
  output logic      si_o
);
  // Idle bus: deselected, clock low, data at an arbitrary level.
  initial begin
    sel_n_o = 1'b1;
    sck_o   = 1'b0;
    si_o    = 1'b0;
  end

  // Sends the top n bits of frm, MSB first, each phase six cycles long.
  // A write frame shorter than 32 bits is an aborted write.
  task automatic send(input logic [31:0] frm, input int n);
    @(posedge mclk_i);
    sel_n_o <= 1'b0;
    repeat (6) @(posedge mclk_i);
    for (int i = 31; i > 31 - n; i--) begin
      sck_o <= 1'b1;
      si_o  <= frm[i];
      repeat (6) @(posedge mclk_i);
      sck_o <= 1'b0;
      repeat (6) @(posedge mclk_i);
    end
    // Released data shows the inverse so a stale bit cannot pass.
    sel_n_o <= 1'b1;
    si_o    <= ~si_o;
    repeat (6) @(posedge mclk_i);
  endtask : send
endmodule : spi_host_model

// ===== test/tdc_config_register_bank_tb_top.sv
// Self-checking bench for the configuration register bank.
// Assumes the host model drives the serial pins; the bench drives the rest.
`timescale 1ns/10ps
module tdc_config_register_bank_tb_top;
  localparam logic [23:0] DEF [6] = '{24'h000668, 24'h554000, 24'h200000,
                                      24'h180000, 24'h200000, 24'h000000};
  logic        mclk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        hw_n   = 1'b1;
  logic        ce     = 1'b1;
  logic [2:0]  ev_pin = 3'h0;
  logic [2:0]  gate   = 3'h7;
  logic [2:0]  irq_in = 3'h0;
  logic        sel_n, sck, si, lr, aci, ace, tcs, irq_n;
  logic [2:0]  ev_o;
  logic [23:0] cfg [6];
  logic [23:0] model [6];
  logic [23:0] seen [6];
  logic [27:0] exp_q [$];
  int          errors  = 0;
  int          checked = 0;

  always #5 mclk_i = ~mclk_i;

  spi_host_model host (.mclk_i(mclk_i), .sel_n_o(sel_n), .sck_o(sck),
                       .si_o(si));

  tdc_config_register_bank dut (
    .mclk_i(mclk_i), .srst_i(srst_i), .ce_i(ce), .hw_reset_n_i(hw_n),
    .spi_sel_n_i(sel_n), .spi_sck_i(sck), .spi_si_i(si),
    .start_i(ev_pin[0]), .stop_a_i(ev_pin[1]), .stop_b_i(ev_pin[2]),
    .start_gate_i(gate[0]), .stop_a_gate_i(gate[1]),
    .stop_b_gate_i(gate[2]), .alu_irq_i(irq_in[0]),
    .end_hits_irq_i(irq_in[1]), .timeout_irq_i(irq_in[2]),
    .cfg0_o(cfg[0]), .cfg1_o(cfg[1]), .cfg2_o(cfg[2]), .cfg3_o(cfg[3]),
    .cfg4_o(cfg[4]), .cfg5_o(cfg[5]), .start_event_o(ev_o[0]),
    .stop_a_event_o(ev_o[1]), .stop_b_event_o(ev_o[2]),
    .long_range_select_o(lr), .auto_cal_inhibit_o(aci),
    .alu_cal_enable_o(ace), .temp_cycle_clock_select_o(tcs),
    .irq_out_n_o(irq_n));

  // ************************************************************
  // Comparison, verdict and scoreboard.
  // ************************************************************
  task automatic chk(input string what, input logic [23:0] exp,
                     input logic [23:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic end_sim();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim

  // Every word change and event pulse must match the oldest note, so a
  // refused frame that still lands is caught as an unexpected change.
  always @(posedge mclk_i) begin
    logic [27:0] n;
    #1;
    if (srst_i) seen = cfg;
    else begin
      for (int w = 0; w < 6; w++) begin
        if (cfg[w] !== seen[w]) begin
          n = exp_q.size() > 0 ? exp_q.pop_front() : 28'hFFFFFFF;
          chk("word index", {20'h0, n[27:24]}, 24'(w));
          chk("word value", n[23:0], cfg[w]);
          seen[w] = cfg[w];
        end
      end
      for (int c = 0; c < 3; c++) begin
        if (ev_o[c] === 1'b1) begin
          n = exp_q.size() > 0 ? exp_q.pop_front() : 28'hFFFFFFF;
          chk("event channel", {20'h0, n[27:24]}, 24'(8 + c));
        end
      end
    end
  end

  // ************************************************************
  // Stimulus tasks.
  // ************************************************************
  task automatic drain();
    for (int i = 0; i < 3000 && exp_q.size() != 0; i++) @(posedge mclk_i);
    if (exp_q.size() != 0) begin
      errors++;
      $display("[FAIL] queue expected 0 seen %0d", exp_q.size());
      end_sim();
    end
    repeat (4) @(posedge mclk_i);
  endtask : drain

  task automatic wr(input logic [2:0] a, input logic [23:0] d);
    if (model[a] !== d) exp_q.push_back({1'b0, a, d});
    model[a] = d;
    host.send({5'h10, a, d}, 32);
    drain();
  endtask : wr

  // Notes the reload of every word that differs from its default.
  task automatic expect_defaults();
    for (int w = 0; w < 6; w++) begin
      if (model[w] !== DEF[w]) exp_q.push_back({4'(w), DEF[w]});
      model[w] = DEF[w];
    end
  endtask : expect_defaults

  task automatic rand_writes();
    logic [23:0] d;
    for (int a = 0; a < 6; a++) begin
      d = 24'($urandom());
      if (a == 1) d[14] = 1'b1;
      if (a == 2) d[23:21] = 3'h0;
      if (a == 4) d[23:19] = 5'h04;
      wr(3'(a), d);
    end
  endtask : rand_writes

  task automatic derived();
    repeat (3) @(posedge mclk_i);
    #1;
    chk("long range", {23'h0, model[0][3]}, {23'h0, lr});
    chk("cal inhibit", {23'h0, model[0][4]}, {23'h0, aci});
    chk("alu cal", {23'h0, model[0][5] | model[0][3]}, {23'h0, ace});
    chk("temp clock", {23'h0, model[0][6]}, {23'h0, tcs});
  endtask : derived

  task automatic edge_pin(input int c, input logic lvl, input bit counted);
    if (counted) exp_q.push_back({4'(8 + c), 24'h0});
    @(posedge mclk_i);
    ev_pin[c] <= lvl;
    repeat (12) @(posedge mclk_i);
  endtask : edge_pin

  // ************************************************************
  // Main sequence.
  // ************************************************************
  initial begin
    void'($urandom(49));
    repeat (8) @(posedge mclk_i);
    srst_i <= 1'b0;
    @(posedge mclk_i);
    #1;
    for (int w = 0; w < 6; w++) chk("reset word", DEF[w], cfg[w]);
    model = DEF;
    derived();
    $display("test reset done");
    rand_writes();
    derived();
    for (int b = 0; b < 4; b++) begin
      wr(3'h0, {16'h0, 1'b0, b[1], 1'b0, 1'b0, b[0], 3'h0});
      derived();
    end
    $display("test write done");
    host.send({5'h10, 3'h1, 24'hABCDEF}, 16);
    host.send({8'hB1, 24'h123456}, 32);
    host.send({5'h10, 3'h6, 24'h654321}, 32);
    // With the clock enable low the whole frame must be lost.
    ce <= 1'b0;
    host.send({5'h10, 3'h5, 24'h00A5A5}, 32);
    ce <= 1'b1;
    drain();
    $display("test refusal done");
    for (int g = 0; g < 2; g++) begin
      gate <= g[0] ? 3'h0 : 3'h7;
      for (int inv = 0; inv < 2; inv++) begin
        wr(3'h0, {21'h000334, {3{inv[0]}}});
        for (int c = 0; c < 3; c++) begin
          edge_pin(c, 1'b1, g == 0 && inv == 0);
          edge_pin(c, 1'b0, g == 0 && inv == 1);
        end
      end
    end
    gate <= 3'h7;
    drain();
    $display("test event done");
    for (int e = 0; e < 4; e++) begin
      wr(3'h2, e < 3 ? 24'(1) << (21 + e) : 24'h0);
      for (int s = 0; s < 3; s++) begin
        @(posedge mclk_i);
        irq_in <= 3'(1) << s;
        repeat (3) @(posedge mclk_i);
        #1;
        chk("irq level", {23'h0, !(e == s)}, {23'h0, irq_n});
        @(posedge mclk_i);
        irq_in <= 3'h0;
        repeat (3) @(posedge mclk_i);
        #1;
        chk("irq idle", 24'h1, {23'h0, irq_n});
      end
    end
    $display("test irq done");
    rand_writes();
    expect_defaults();
    hw_n <= 1'b0;
    host.send({5'h10, 3'h3, 24'h0F0F0F}, 32);
    hw_n <= 1'b1;
    drain();
    rand_writes();
    expect_defaults();
    host.send({8'h50, 24'h0}, 8);
    drain();
    derived();
    $display("test default reload done");
    end_sim();
  end
endmodule : tdc_config_register_bank_tb_top

// ===== verilog/pin_sync.sv
// Three-stage synchroniser for a group of asynchronous pins.
// Assumes the pins are independent levels; a change is taken once the
// second and third stages agree, so a one-stage glitch is filtered.
`timescale 1ns/10ps
module pin_sync #(
  parameter int          W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         mclk_i,
  input  wire logic         srst_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] level_o
);

  logic [W-1:0] meta;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;
  logic [W-1:0] next_level;

  // **************************************************************
  // Agreement filter.
  // **************************************************************
  // Only the second and third stages are compared; the first stage may
  // be metastable and is read by the second stage alone.
  always_comb begin
    next_level = level_o;
    for (int i = 0; i < W; i++) begin
      if (stage2[i] == stage3[i]) begin
        next_level[i] = stage3[i];
      end
    end
  end

  // Registers of the chain.
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      meta    <= RST_VAL;
      stage2  <= RST_VAL;
      stage3  <= RST_VAL;
      level_o <= RST_VAL;
    end else if (ce_i) begin
      meta    <= pin_i;
      stage2  <= meta;
      stage3  <= stage2;
      level_o <= next_level;
    end
  end

endmodule : pin_sync

// ===== verilog/tdc_cfg_pkg.sv
// Shared constants of the converter's configuration register bank.
// Assumes a single 100 MHz system clock; no other package is needed.
package tdc_cfg_pkg;

  // **************************************************************
  // Sizes of the serial frame and of the word store.
  // **************************************************************
  localparam int             WORD_W     = 24;
  localparam int             NUM_WORDS  = 6;
  localparam int             OPC_W      = 8;
  localparam int             ADDR_W     = 3;
  localparam int             CNT_W      = 6;
  localparam int             PIN_W      = 10;
  localparam logic [5:0]     CNT_OPC_END   = 6'h08;
  localparam logic [5:0]     CNT_FRAME_END = 6'h20;
  localparam logic [5:0]     CNT_ONE       = 6'h01;

  // **************************************************************
  // Opcodes and word addresses.
  // **************************************************************
  localparam logic [4:0]     OPC_WRITE_HEAD = 5'h10;
  localparam logic [7:0]     OPC_POWER_ON   = 8'h50;
  localparam logic [2:0]     ADDR_CFG0      = 3'h0;
  localparam logic [2:0]     ADDR_CFG2      = 3'h2;
  localparam logic [2:0]     ADDR_LAST      = 3'h5;

  // **************************************************************
  // Field positions in word 0 and word 2.
  // **************************************************************
  localparam int             BIT_START_INV  = 0;
  localparam int             BIT_STOP_A_INV = 1;
  localparam int             BIT_STOP_B_INV = 2;
  localparam int             BIT_LONG_RANGE = 3;
  localparam int             BIT_CAL_INHIB  = 4;
  localparam int             BIT_ALU_CAL    = 5;
  localparam int             BIT_TEMP_CLK   = 6;
  localparam int             BIT_IRQ_ALU    = 21;
  localparam int             BIT_IRQ_HITS   = 22;
  localparam int             BIT_IRQ_TIMEO  = 23;

  // **************************************************************
  // Power-on values of the six words.
  // **************************************************************
  localparam logic [23:0]    CFG0_RST = 24'h000668;
  localparam logic [23:0]    CFG1_RST = 24'h554000;
  localparam logic [23:0]    CFG2_RST = 24'h200000;
  localparam logic [23:0]    CFG3_RST = 24'h180000;
  localparam logic [23:0]    CFG4_RST = 24'h200000;
  localparam logic [23:0]    CFG5_RST = 24'h000000;

  // Resting levels of the synchronised pins: select and reset idle high,
  // gates idle high as if tied, event inputs idle low.
  localparam logic [9:0]     PIN_RST  = 10'h389;

  // Serial receiver states, one-hot.
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_OPCODE = 4'h2,
    ST_DATA   = 4'h4,
    ST_SKIP   = 4'h8
  } spi_state_t;

  // Power-on value of a word, by address.
  function automatic logic [23:0] cfg_default(input logic [2:0] idx);
    logic [23:0] val;
    val = CFG5_RST;
    case (idx)
      3'h0: val = CFG0_RST;
      3'h1: val = CFG1_RST;
      3'h2: val = CFG2_RST;
      3'h3: val = CFG3_RST;
      3'h4: val = CFG4_RST;
      default: val = CFG5_RST;
    endcase
    return val;
  endfunction : cfg_default

endpackage : tdc_cfg_pkg

// ===== verilog/tdc_config_register_bank.sv
// Configuration write-register bank of a time-to-digital converter,
// with its serial write port, channel gating and interrupt combiner.
// Assumes the serial, hw_reset_n_i, event and gate pins are asynchronous to mclk_i and that the serial clock
// runs well below a quarter of mclk_i.
`timescale 1ns/10ps
module tdc_config_register_bank (
  input  wire logic        mclk_i,
  input  wire logic        srst_i,
  input  wire logic        ce_i,
  input  wire logic        hw_reset_n_i,
  input  wire logic        spi_sel_n_i,
  input  wire logic        spi_sck_i,
  input  wire logic        spi_si_i,
  input  wire logic        start_i,
  input  wire logic        stop_a_i,
  input  wire logic        stop_b_i,
  input  wire logic        start_gate_i,
  input  wire logic        stop_a_gate_i,
  input  wire logic        stop_b_gate_i,
  input  wire logic        alu_irq_i,
  input  wire logic        end_hits_irq_i,
  input  wire logic        timeout_irq_i,
  output logic [23:0]      cfg0_o,
  output logic [23:0]      cfg1_o,
  output logic [23:0]      cfg2_o,
  output logic [23:0]      cfg3_o,
  output logic [23:0]      cfg4_o,
  output logic [23:0]      cfg5_o,
  output logic             start_event_o,
  output logic             stop_a_event_o,
  output logic             stop_b_event_o,
  output logic             long_range_select_o,
  output logic             auto_cal_inhibit_o,
  output logic             alu_cal_enable_o,
  output logic             temp_cycle_clock_select_o,
  output logic             irq_out_n_o
);

  // **************************************************************
  // Pin synchronisation.
  // **************************************************************
  logic [9:0]  pins;
  logic        sel_n_s;
  logic        sck_s;
  logic        si_s;
  logic        hw_rst_n_s;
  logic [2:0]  chan_s;
  logic [2:0]  gate_s;

  pin_sync #(
    .W       (tdc_cfg_pkg::PIN_W),
    .RST_VAL (tdc_cfg_pkg::PIN_RST)
  ) u_pin_sync (
    .mclk_i  (mclk_i),
    .srst_i  (srst_i),
    .ce_i    (ce_i),
    .pin_i   ({stop_b_gate_i, stop_a_gate_i, start_gate_i,
               stop_b_i, stop_a_i, start_i,
               hw_reset_n_i, spi_si_i, spi_sck_i, spi_sel_n_i}),
    .level_o (pins)
  );

  assign sel_n_s    = pins[0];
  assign sck_s      = pins[1];
  assign si_s       = pins[2];
  assign hw_rst_n_s = pins[3];
  assign chan_s     = pins[6:4];
  assign gate_s     = pins[9:7];

  // **************************************************************
  // Serial receiver.
  // **************************************************************
  tdc_cfg_pkg::spi_state_t state;
  tdc_cfg_pkg::spi_state_t next_state;
  logic [5:0]  bit_cnt;
  logic [5:0]  next_bit_cnt;
  logic [23:0] shift;
  logic [23:0] next_shift;
  logic [7:0]  opcode;
  logic [7:0]  next_opcode;
  logic        sck_prev;
  logic        sck_fall;
  logic        wr_en;
  logic [2:0]  wr_addr;
  logic [23:0] wr_data;
  logic        por_cmd;

  // Data is taken on the falling serial clock, MSB first. A frame that
  // loses its select early is dropped, so a word never half-updates.
  assign sck_fall = sck_prev & ~sck_s;

  always_comb begin
    next_state   = state;
    next_bit_cnt = bit_cnt;
    next_shift   = shift;
    next_opcode  = opcode;
    wr_en        = 1'b0;
    wr_addr      = opcode[2:0];
    wr_data      = {shift[22:0], si_s};
    por_cmd      = 1'b0;
    unique case (state)
      tdc_cfg_pkg::ST_IDLE: begin
        next_bit_cnt = '0;
        if (!sel_n_s) begin
          next_state = tdc_cfg_pkg::ST_OPCODE;
        end
      end
      tdc_cfg_pkg::ST_OPCODE: begin
        if (sel_n_s) begin
          next_state = tdc_cfg_pkg::ST_IDLE;
        end else if (sck_fall) begin
          next_shift   = {shift[22:0], si_s};
          next_bit_cnt = bit_cnt + tdc_cfg_pkg::CNT_ONE;
          if (next_bit_cnt == tdc_cfg_pkg::CNT_OPC_END) begin
            next_opcode = next_shift[7:0];
            if (next_opcode[7:3] == tdc_cfg_pkg::OPC_WRITE_HEAD) begin
              next_state = tdc_cfg_pkg::ST_DATA;
            end else begin
              por_cmd    = (next_opcode == tdc_cfg_pkg::OPC_POWER_ON);
              next_state = tdc_cfg_pkg::ST_SKIP;
            end
          end
        end
      end
      tdc_cfg_pkg::ST_DATA: begin
        if (sel_n_s) begin
          next_state = tdc_cfg_pkg::ST_IDLE;
        end else if (sck_fall) begin
          next_shift   = {shift[22:0], si_s};
          next_bit_cnt = bit_cnt + tdc_cfg_pkg::CNT_ONE;
          if (next_bit_cnt == tdc_cfg_pkg::CNT_FRAME_END) begin
            // Addresses 6 and 7 hold no word and are ignored.
            wr_en      = (opcode[2:0] <= tdc_cfg_pkg::ADDR_LAST);
            next_state = tdc_cfg_pkg::ST_SKIP;
          end
        end
      end
      tdc_cfg_pkg::ST_SKIP: begin
        if (sel_n_s) begin
          next_state = tdc_cfg_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = tdc_cfg_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      state    <= tdc_cfg_pkg::ST_IDLE;
      bit_cnt  <= '0;
      shift    <= '0;
      opcode   <= '0;
      sck_prev <= 1'b0;
    end else if (ce_i) begin
      state    <= next_state;
      bit_cnt  <= next_bit_cnt;
      shift    <= next_shift;
      opcode   <= next_opcode;
      sck_prev <= sck_s;
    end
  end

  // **************************************************************
  // Word store.
  // **************************************************************
  logic [23:0] cfg      [tdc_cfg_pkg::NUM_WORDS];
  logic [23:0] next_cfg [tdc_cfg_pkg::NUM_WORDS];

  // Defaults win over a write landing in the same cycle, since a reset
  // pin or power-on command means the host state is void.
  always_comb begin
    for (int i = 0; i < tdc_cfg_pkg::NUM_WORDS; i++) begin
      next_cfg[i] = cfg[i];
      if (!hw_rst_n_s || por_cmd) begin
        next_cfg[i] = tdc_cfg_pkg::cfg_default(3'(i));
      end else if (wr_en && (wr_addr == 3'(i))) begin
        next_cfg[i] = wr_data;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    for (int i = 0; i < tdc_cfg_pkg::NUM_WORDS; i++) begin
      if (srst_i) begin
        cfg[i] <= tdc_cfg_pkg::cfg_default(3'(i));
      end else if (ce_i) begin
        cfg[i] <= next_cfg[i];
      end
    end
  end

  assign cfg0_o = cfg[0];
  assign cfg1_o = cfg[1];
  assign cfg2_o = cfg[2];
  assign cfg3_o = cfg[3];
  assign cfg4_o = cfg[4];
  assign cfg5_o = cfg[5];

  // Mode bits steer the measurement core straight from the store.
  assign long_range_select_o       = cfg[0][tdc_cfg_pkg::BIT_LONG_RANGE];
  assign auto_cal_inhibit_o        = cfg[0][tdc_cfg_pkg::BIT_CAL_INHIB];
  assign temp_cycle_clock_select_o = cfg[0][tdc_cfg_pkg::BIT_TEMP_CLK];

  // **************************************************************
  // Channel events, calibration enable and interrupt pin.
  // **************************************************************
  logic [2:0]  chan_prev;
  logic [2:0]  edge_inv;
  logic [2:0]  next_event;
  logic        next_alu_cal;
  logic        next_irq_n;
  logic [2:0]  irq_src;

  assign edge_inv = cfg[0][tdc_cfg_pkg::BIT_STOP_B_INV:
                           tdc_cfg_pkg::BIT_START_INV];
  assign irq_src  = {timeout_irq_i, end_hits_irq_i, alu_irq_i};

  // The edge is judged on the raw synchronised level, so flipping the
  // polarity bit does not itself fake an event.
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      next_event[i] = gate_s[i] & (edge_inv[i] ?
                      (chan_prev[i] & ~chan_s[i]) :
                      (~chan_prev[i] & chan_s[i]));
    end
    // Calibration may only be switched off in the short range.
    next_alu_cal = cfg[0][tdc_cfg_pkg::BIT_ALU_CAL] |
                   cfg[0][tdc_cfg_pkg::BIT_LONG_RANGE];
    next_irq_n   = ~|(irq_src & cfg[2][tdc_cfg_pkg::BIT_IRQ_TIMEO:
                                       tdc_cfg_pkg::BIT_IRQ_ALU]);
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      chan_prev        <= '0;
      start_event_o    <= 1'b0;
      stop_a_event_o   <= 1'b0;
      stop_b_event_o   <= 1'b0;
      alu_cal_enable_o <= 1'b1;
      irq_out_n_o      <= 1'b1;
    end else if (ce_i) begin
      chan_prev        <= chan_s;
      start_event_o    <= next_event[0];
      stop_a_event_o   <= next_event[1];
      stop_b_event_o   <= next_event[2];
      alu_cal_enable_o <= next_alu_cal;
      irq_out_n_o      <= next_irq_n;
    end
  end

  // **************************************************************
  // Checks.
  // **************************************************************
  AST_WRITE_WHOLE: assert property (@(posedge mclk_i) disable iff (srst_i)
    (ce_i && wr_en && hw_rst_n_s) |=> (cfg[$past(wr_addr)] == $past(wr_data)))
    else $error("Written word did not take the whole frame data.");

  AST_WRITE_OPCODE: assert property (@(posedge mclk_i) disable iff (srst_i)
    wr_en |-> (opcode[7:3] == tdc_cfg_pkg::OPC_WRITE_HEAD))
    else $error("Word written without a write opcode.");

  AST_ABORT_NO_WRITE: assert property (@(posedge mclk_i) disable iff (srst_i)
    (sel_n_s && state == tdc_cfg_pkg::ST_DATA) |-> !wr_en)
    else $error("Aborted frame wrote a word.");

  AST_RESET_DEFAULT: assert property (@(posedge mclk_i)
    srst_i |=> (cfg0_o == tdc_cfg_pkg::CFG0_RST &&
                cfg1_o == tdc_cfg_pkg::CFG1_RST &&
                cfg3_o == tdc_cfg_pkg::CFG3_RST))
    else $error("Words missed their defaults after reset.");

  AST_GATE_BLOCKS: assert property (@(posedge mclk_i) disable iff (srst_i)
    (ce_i && !gate_s[1]) |=> !stop_a_event_o)
    else $error("Stop A event passed a closed gate.");

  AST_FALL_EDGE: assert property (@(posedge mclk_i) disable iff (srst_i)
    (ce_i && gate_s[0] && edge_inv[0] && chan_prev[0] && !chan_s[0])
      |=> start_event_o)
    else $error("Inverted start missed a falling edge.");

  AST_ALU_CAL_RANGE: assert property (@(posedge mclk_i) disable iff (srst_i)
    (ce_i && long_range_select_o) |=> alu_cal_enable_o)
    else $error("ALU calibration off in the long range.");

  AST_IRQ_ENABLED: assert property (@(posedge mclk_i) disable iff (srst_i)
    (ce_i && timeout_irq_i && cfg2_o[tdc_cfg_pkg::BIT_IRQ_TIMEO]) |=> !irq_out_n_o)
    else $error("Enabled timeout source did not pull the interrupt low.");

  AST_IRQ_MASKED: assert property (@(posedge mclk_i) disable iff (srst_i)
    (ce_i && cfg2_o[tdc_cfg_pkg::BIT_IRQ_TIMEO:tdc_cfg_pkg::BIT_IRQ_ALU] == 3'h0)
      |=> irq_out_n_o)
    else $error("Interrupt asserted with every source disabled.");

  AST_MODE_BITS: assert property (@(posedge mclk_i) disable iff (srst_i)
    (ce_i && hw_rst_n_s && wr_en && wr_addr == tdc_cfg_pkg::ADDR_CFG0)
      |=> (auto_cal_inhibit_o == $past(wr_data[4]) &&
           temp_cycle_clock_select_o == $past(wr_data[6])))
    else $error("Mode outputs did not follow a word 0 write.");

endmodule : tdc_config_register_bank
